//--- sep_top.v
// Two-wire serial memory target: pins, byte engine, array, serial number.
// Assumes the bus controller drives the serial clock and a pull-up on data;
// the testbench resolves the open-drain data wire from o_sda_oe.
`include "sep_consts.vh"

module sep_top #(
   parameter integer P_TWR_CYC = `SEP_TWR_CYC,
   parameter [127:0] P_SERIAL = 128'h0F1E2D3C4B5A69788796A5B4C3D2E1F0
)(
   input wire i_mclk,
   input wire i_sys_rst,
   input wire i_ce,
   input wire i_scl,
   input wire i_sda,
   input wire i_wp,
   output reg o_sda_out,
   output reg o_sda_oe,
   output reg o_busy
);

   // ********************
   // Local constants
   // ********************
   // Bus states
   localparam [2:0] S_IDLE = 3'h0;
   localparam [2:0] S_RX = 3'h1;
   localparam [2:0] S_ACK = 3'h2;
   localparam [2:0] S_TX = 3'h3;
   localparam [2:0] S_MACK = 3'h4;
   // Byte phases of a received frame
   localparam [1:0] PH_CTRL = 2'h0;
   localparam [1:0] PH_ADDR = 2'h1;
   localparam [1:0] PH_DATA = 2'h2;
   // Program engine states
   localparam [1:0] P_IDLE = 2'h0;
   localparam [1:0] P_DRAIN = 2'h1;
   localparam [1:0] P_WAIT = 2'h2;
   // Last count of the program timer, cut to the timer width on purpose
   localparam integer L_TWR_LAST = P_TWR_CYC - 1;
   localparam [`SEP_TMR_W-1:0] L_TWR_END = L_TWR_LAST[`SEP_TMR_W-1:0];

   // ********************
   // Functions
   // ********************
   // Byte of the serial number at an index, first byte most significant
   function [7:0] sn_byte;
      input [3:0] idx;
      reg [127:0] t;
      begin
         t = P_SERIAL << {idx, 3'b000};
         sn_byte = t[127:120];
      end
   endfunction

   // Next read address: serial space wraps in 16, array wraps whole
   function [`SEP_ADDR_W-1:0] next_addr;
      input sn;
      input [`SEP_ADDR_W-1:0] a;
      begin
         if (sn) begin
            next_addr = {a[`SEP_ADDR_W-1:4], a[3:0] + 4'h1};
         end else begin
            next_addr = a + 11'h001;
         end
      end
   endfunction

   // ********************
   // Declarations
   // ********************
   wire scl_s; // Synchronised clock pin
   wire sda_s; // Synchronised data pin
   wire wp_s; // Synchronised write-protect pin
   reg scl_p_q; // Clock level one cycle back
   reg sda_p_q; // Data level one cycle back
   reg [2:0] st_q; // Bus state
   reg [1:0] ph_q; // Which byte is being received
   reg [3:0] cnt_q; // Bit counter
   reg [7:0] sh_q; // Receive shifter
   reg [7:0] tx_q; // Transmit shifter
   reg rd_q; // Send a byte after the coming acknowledge
   reg sn_q; // Frame addresses the serial number
   reg prot_q; // Write-protect caught at frame start
   reg pend_q; // Bytes waiting to be programmed
   reg [`SEP_ADDR_W-1:0] addr_q; // Current address
   reg [1:0] prg_q; // Program engine state
   reg [`SEP_TMR_W-1:0] tmr_q; // Program timer
   reg [7:0] mem [0:`SEP_MEM_DEPTH-1]; // User array
   reg push_q; // Buffer write strobe
   reg [`SEP_FIFO_W-1:0] push_d_q; // Buffer write word
   wire f_in_rdy; // Buffer has room
   wire f_out_vld; // Buffer holds a byte
   wire [`SEP_FIFO_W-1:0] f_out; // Oldest buffered word
   wire drain = (prg_q == P_DRAIN); // Drain side ready
   wire fire = f_out_vld & drain; // One byte into the array
   wire busy = (prg_q != P_IDLE); // Programming in progress
   wire [7:0] sn_cur = sn_byte(addr_q[3:0]); // Serial number byte at the current index

   // ********************
   // Pin synchronisers
   // ********************
   // Clock idles high, so its synchroniser resets high
   sep_sync #(.P_RST(1'b1)) u_scl (
      .i_mclk(i_mclk),
      .i_sys_rst(i_sys_rst),
      .i_ce(i_ce),
      .i_pin(i_scl),
      .o_lvl(scl_s)
   );

   // Data line released reads high through the pull-up
   sep_sync #(.P_RST(1'b1)) u_sda (
      .i_mclk(i_mclk),
      .i_sys_rst(i_sys_rst),
      .i_ce(i_ce),
      .i_pin(i_sda),
      .o_lvl(sda_s)
   );

   // Protect pin starts as low, like the pull-down on a floating pin
   sep_sync #(.P_RST(1'b0)) u_wp (
      .i_mclk(i_mclk),
      .i_sys_rst(i_sys_rst),
      .i_ce(i_ce),
      .i_pin(i_wp),
      .o_lvl(wp_s)
   );

   // ********************
   // Edge and framing detection
   // ********************
   // Sampling at 125 MHz leaves many cycles per bit even at 1 MHz
   wire scl_rise = scl_s & ~scl_p_q;
   wire scl_fall = ~scl_s & scl_p_q;
   wire start = scl_s & scl_p_q & sda_p_q & ~sda_s;
   wire stop = scl_s & scl_p_q & ~sda_p_q & sda_s;

   // Previous levels for edge finding
   always @(posedge i_mclk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         scl_p_q <= 1'b1;
         sda_p_q <= 1'b1;
      end else if (i_ce) begin
         scl_p_q <= scl_s;
         sda_p_q <= sda_s;
      end
   end

   // ********************
   // Write buffer
   // ********************
   // Page bytes wait here until the stop starts programming
   sep_fifo #(
      .W(`SEP_FIFO_W),
      .D(`SEP_FIFO_D),
      .AW(`SEP_FIFO_AW)
   ) u_fifo (
      .i_mclk(i_mclk),
      .i_sys_rst(i_sys_rst),
      .i_ce(i_ce),
      .i_in_valid(push_q),
      .o_in_ready(f_in_rdy),
      .i_in_data(push_d_q),
      .o_out_valid(f_out_vld),
      .i_out_ready(drain),
      .o_out_data(f_out)
   );

   // ********************
   // Bus byte engine
   // ********************
   // Receives, acknowledges and sends bytes under the serial clock
   always @(posedge i_mclk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         st_q <= S_IDLE;
         ph_q <= PH_CTRL;
         cnt_q <= 4'h0;
         sh_q <= 8'h00;
         tx_q <= 8'h00;
         rd_q <= 1'b0;
         sn_q <= 1'b0;
         prot_q <= 1'b0;
         pend_q <= 1'b0;
         addr_q <= 11'h000;
         push_q <= 1'b0;
         push_d_q <= 19'h00000;
         o_sda_out <= 1'b0;
         o_sda_oe <= 1'b0;
      end else if (i_ce) begin
         push_q <= 1'b0;
         // Never drives high: level is low, only the enable moves
         o_sda_out <= 1'b0;
         if (start) begin
            // Start or repeated start: expect a control byte
            st_q <= S_RX;
            ph_q <= PH_CTRL;
            cnt_q <= 4'h0;
            o_sda_oe <= 1'b0;
         end else if (stop) begin
            // Stop: release the line, programming begins elsewhere
            st_q <= S_IDLE;
            o_sda_oe <= 1'b0;
            pend_q <= 1'b0;
         end else begin
            case (st_q)
               S_IDLE: begin
                  // Wait for a start
                  o_sda_oe <= 1'b0;
               end
               S_RX: begin
                  if (scl_rise && cnt_q != `SEP_BITS) begin
                     // Shift in one bit on the rising edge
                     sh_q <= {sh_q[6:0], sda_s};
                     cnt_q <= cnt_q + 4'h1;
                  end else if (scl_fall && cnt_q == `SEP_BITS) begin
                     // Whole byte in: decide the answer after the fall
                     case (ph_q)
                        PH_CTRL: begin
                           if ((sh_q[7:4] == `SEP_CODE_MEM || sh_q[7:4] == `SEP_CODE_SN) && !busy) begin
                              sn_q <= (sh_q[7:4] == `SEP_CODE_SN);
                              rd_q <= sh_q[0];
                              if (sh_q[7:4] == `SEP_CODE_MEM) begin
                                 // Block bits give the top of the 11-bit address
                                 addr_q[10:8] <= sh_q[3:1];
                              end
                              // Protect level held for the whole write
                              prot_q <= wp_s;
                              ph_q <= PH_ADDR;
                              o_sda_oe <= 1'b1;
                              st_q <= S_ACK;
                           end else begin
                              // Not ours or busy: no acknowledge
                              st_q <= S_IDLE;
                           end
                        end
                        PH_ADDR: begin
                           // Word address for random read or write
                           addr_q[7:0] <= sh_q;
                           ph_q <= PH_DATA;
                           o_sda_oe <= 1'b1;
                           st_q <= S_ACK;
                        end
                        default: begin
                           if (sn_q || prot_q || !f_in_rdy) begin
                              // Serial number never written
                              // Protected array refuses the byte
                              st_q <= S_IDLE;
                           end else begin
                              // Buffer the byte for the page write
                              push_q <= 1'b1;
                              push_d_q <= {addr_q, sh_q};
                              pend_q <= 1'b1;
                              // Roll over inside the 16-byte page
                              addr_q[3:0] <= addr_q[3:0] + 4'h1;
                              o_sda_oe <= 1'b1;
                              st_q <= S_ACK;
                           end
                        end
                     endcase
                  end
               end
               S_ACK: begin
                  if (scl_fall) begin
                     if (rd_q) begin
                        // Load the next byte, drive its first bit after the fall
                        if (sn_q) begin
                           o_sda_oe <= ~sn_cur[7];
                           tx_q <= {sn_cur[6:0], 1'b0};
                        end else begin
                           o_sda_oe <= ~mem[addr_q][7];
                           tx_q <= {mem[addr_q][6:0], 1'b0};
                        end
                        // Sequential read steps to the next address
                        addr_q <= next_addr(sn_q, addr_q);
                        cnt_q <= 4'h1;
                        st_q <= S_TX;
                     end else begin
                        // Release after the acknowledge, receive next byte
                        o_sda_oe <= 1'b0;
                        cnt_q <= 4'h0;
                        st_q <= S_RX;
                     end
                  end
               end
               S_TX: begin
                  if (scl_fall) begin
                     if (cnt_q == `SEP_BITS) begin
                        // Let the controller answer
                        o_sda_oe <= 1'b0;
                        st_q <= S_MACK;
                     end else begin
                        // Next bit, only pull low for a zero
                        o_sda_oe <= ~tx_q[7];
                        tx_q <= {tx_q[6:0], 1'b0};
                        cnt_q <= cnt_q + 4'h1;
                     end
                  end
               end
               S_MACK: begin
                  if (scl_rise) begin
                     // Acknowledge continues the read, otherwise wait for stop
                     st_q <= sda_s ? S_IDLE : S_ACK;
                  end
               end
               default: begin
                  st_q <= S_IDLE;
               end
            endcase
         end
      end
   end

   // ********************
   // Array write port
   // ********************
   // Buffered page bytes land in the array one per cycle
   always @(posedge i_mclk) begin
      if (i_ce && fire) begin
         mem[f_out[18:8]] <= f_out[7:0];
      end
   end

   // ********************
   // Program engine
   // ********************
   // Drains the buffer then holds busy for the program time
   always @(posedge i_mclk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         prg_q <= P_IDLE;
         tmr_q <= 20'h00000;
         o_busy <= 1'b0;
      end else if (i_ce) begin
         o_busy <= busy;
         case (prg_q)
            P_IDLE: begin
               // A stop after accepted bytes starts the cycle
               if (stop && pend_q) begin
                  prg_q <= P_DRAIN;
               end
            end
            P_DRAIN: begin
               // Empty buffer: start the self-timed wait
               if (!f_out_vld) begin
                  tmr_q <= 20'h00000;
                  prg_q <= P_WAIT;
               end
            end
            P_WAIT: begin
               // Count without any serial clock
               if (tmr_q == L_TWR_END) begin
                  prg_q <= P_IDLE;
               end else begin
                  tmr_q <= tmr_q + 20'h00001;
               end
            end
            default: begin
               prg_q <= P_IDLE;
            end
         endcase
      end
   end

endmodule

//--- sep_consts.vh
// Constants shared by the serial memory target files.
// Assumes a 125 MHz system clock; included by its bare name.
`ifndef SEP_CONSTS_VH
`define SEP_CONSTS_VH

// ********************
// Memory organisation
// ********************
`define SEP_ADDR_W 11
`define SEP_MEM_DEPTH 2048
`define SEP_SN_BYTES 16

// ********************
// Control byte codes
// ********************
`define SEP_CODE_MEM 4'hA
`define SEP_CODE_SN 4'hB

// ********************
// Write buffer shape
// ********************
`define SEP_FIFO_W 19
`define SEP_FIFO_D 32
`define SEP_FIFO_AW 5

// ********************
// Timing
// ********************
`define SEP_CLK_NS 8
`define SEP_TWR_NS 5000000
`define SEP_TWR_CYC (`SEP_TWR_NS / `SEP_CLK_NS)
`define SEP_TMR_W 20
`define SEP_BITS 4'h8

`endif

//--- sep_sync.v
// Two-flop synchroniser for one pin input.
// Assumes the pin is asynchronous to i_mclk.
module sep_sync #(
   parameter P_RST = 1'b0
)(
   input wire i_mclk,
   input wire i_sys_rst,
   input wire i_ce,
   input wire i_pin,
   output wire o_lvl
);

   reg s1_q; // First stage, read only by s2_q
   reg s2_q; // Second stage, safe level

   // Two flip-flops in a row, frozen while clock enable is low
   always @(posedge i_mclk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         s1_q <= P_RST;
         s2_q <= P_RST;
      end else if (i_ce) begin
         s1_q <= i_pin;
         s2_q <= s1_q;
      end
   end

   assign o_lvl = s2_q;

endmodule

//--- sep_fifo.v
// Flip-flop FIFO with valid and ready on both sides.
// Assumes depth is a power of two matching AW.
module sep_fifo #(
   parameter W = 19,
   parameter D = 32,
   parameter AW = 5
)(
   input wire i_mclk,
   input wire i_sys_rst,
   input wire i_ce,
   input wire i_in_valid,
   output wire o_in_ready,
   input wire [W-1:0] i_in_data,
   output wire o_out_valid,
   input wire i_out_ready,
   output wire [W-1:0] o_out_data
);

   localparam [AW:0] L_D = D; // Depth at counter width

   reg [W-1:0] mem [0:D-1]; // Storage
   reg [AW-1:0] wp_q; // Write index
   reg [AW-1:0] rp_q; // Read index
   reg [AW:0] cnt_q; // Words held

   wire push = i_in_valid & o_in_ready;
   wire pop = o_out_valid & i_out_ready;

   assign o_in_ready = (cnt_q != L_D);
   assign o_out_valid = (cnt_q != {(AW+1){1'b0}});
   assign o_out_data = mem[rp_q];

   // Storage write, no reset needed for data
   always @(posedge i_mclk) begin
      if (i_ce && push) begin
         mem[wp_q] <= i_in_data;
      end
   end

   // Pointers and fill count
   always @(posedge i_mclk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         wp_q <= {AW{1'b0}};
         rp_q <= {AW{1'b0}};
         cnt_q <= {(AW+1){1'b0}};
      end else if (i_ce) begin
         if (push) begin
            wp_q <= wp_q + 1'b1;
         end
         if (pop) begin
            rp_q <= rp_q + 1'b1;
         end
         if (push && !pop) begin
            cnt_q <= cnt_q + 1'b1;
         end else if (pop && !push) begin
            cnt_q <= cnt_q - 1'b1;
         end
      end
   end

endmodule

//--- sep_top_chk.sv
// Checker for the serial memory target, watching only the top ports.
// Assumes i_mclk runs free and i_sys_rst is asynchronous, active high.
module sep_top_chk #(
   parameter integer P_TWR_CYC = 50
)(
   input wire logic i_mclk,
   input wire logic i_sys_rst,
   input wire logic i_ce,
   input wire logic i_scl,
   input wire logic i_sda,
   input wire logic i_wp,
   input wire logic o_sda_out,
   input wire logic o_sda_oe,
   input wire logic o_busy
);
   logic [19:0] busy_cnt_q; // Consecutive busy cycles

   // Count the length of each program cycle
   always @(posedge i_mclk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         busy_cnt_q <= 20'h00000;
      end else begin
         busy_cnt_q <= o_busy ? busy_cnt_q + 20'h00001 : 20'h00000;
      end
   end

   default clocking @(posedge i_mclk); endclocking
   default disable iff (i_sys_rst);

   // ******************
   // Pin behaviour
   // ******************
   property p_low_only; o_sda_out == 1'b0; endproperty
   a_low_only: assert property (p_low_only)
      else $error("data line driven high");
   property p_rst_quiet; $fell(i_sys_rst) |-> !o_sda_oe && !o_busy; endproperty
   a_rst_quiet: assert property (p_rst_quiet)
      else $error("outputs active after reset");
   property p_chg_low; $changed(o_sda_oe) |-> !i_scl && !$past(i_scl, 2); endproperty
   a_chg_low: assert property (p_chg_low)
      else $error("data drive changed outside clock low");
   property p_hold_high; $rose(i_scl) |-> ##1 $stable(o_sda_oe) [*5]; endproperty
   a_hold_high: assert property (p_hold_high)
      else $error("data drive moved while clock high");

   // ******************
   // Program cycle
   // ******************
   property p_busy_stop; $rose(o_busy) |-> i_scl && i_sda && $past(i_scl, 2); endproperty
   a_busy_stop: assert property (p_busy_stop)
      else $error("program cycle began inside a frame");
   property p_busy_nack; o_busy && $past(o_busy) |-> !$rose(o_sda_oe); endproperty
   a_busy_nack: assert property (p_busy_nack)
      else $error("acknowledge while programming");
   property p_busy_max; o_busy |-> busy_cnt_q < P_TWR_CYC + 40; endproperty
   a_busy_max: assert property (p_busy_max)
      else $error("program cycle too long");
   property p_busy_min; $fell(o_busy) |-> busy_cnt_q >= P_TWR_CYC; endproperty
   a_busy_min: assert property (p_busy_min)
      else $error("program cycle too short");

   c_ack: cover property ($rose(o_sda_oe));
   c_prog: cover property ($fell(o_busy));
   c_wp: cover property (i_wp && $rose(i_scl));
endmodule

bind sep_top sep_top_chk #(.P_TWR_CYC(P_TWR_CYC)) u_chk (.i_mclk(i_mclk), .i_sys_rst(i_sys_rst),
   .i_ce(i_ce), .i_scl(i_scl), .i_sda(i_sda), .i_wp(i_wp), .o_sda_out(o_sda_out),
   .o_sda_oe(o_sda_oe), .o_busy(o_busy));

//--- sep_ctl_model.sv
// Two-wire bus controller model: makes the serial clock, drives open-drain data.
// Assumes a pull-up on data; the device's pull enable arrives on i_dev_oe.
module sep_ctl_model (
   input wire logic i_dev_oe,
   output logic o_scl,
   output wire o_sda
);
   timeunit 1ns;
   timeprecision 100ps;
   logic drv_q = 1'b1; // Own data level, 1 releases the wire
   initial o_scl = 1'b1; // Clock stands high outside frames
   // Wired-AND with pull-up: a released wire reads high
   assign o_sda = drv_q & ~i_dev_oe;

   // One 64 ns slot: data moves only while clock low, read mid-high
   task automatic bit_slot(input logic b, output logic r);
      #8 drv_q = b;
      #32 o_scl = 1'b1;
      #12 r = o_sda;
      #12 o_scl = 1'b0;
   endtask
   // Start or repeated start: data falls while clock high
   task automatic bus_start;
      #8 drv_q = 1'b1;
      #24 o_scl = 1'b1;
      #24 drv_q = 1'b0;
      #24 o_scl = 1'b0;
   endtask
   // Stop: data rises while clock high, clock then stays high
   task automatic bus_stop;
      #8 drv_q = 1'b0;
      #32 o_scl = 1'b1;
      #24 drv_q = 1'b1;
      #40;
   endtask
   // Send a byte MSB first, then read the acknowledge slot
   task automatic wbyte(input logic [7:0] b, output logic ack);
      logic r;
      for (int i = 7; i >= 0; i--) bit_slot(b[i], r);
      bit_slot(1'b1, r);
      ack = ~r;
   endtask
   // Read a byte MSB first; low in the last slot asks for more
   task automatic rbyte(input logic last, output logic [7:0] b);
      logic r;
      for (int i = 7; i >= 0; i--) bit_slot(1'b1, b[i]);
      bit_slot(last, r);
   endtask
endmodule

//--- test_serial_eeprom_bus_pins_protect.sv
// Self-checking bench for the serial memory target.
// Assumes sep_top, sep_ctl_model and the bound checker are compiled alongside.
module test_serial_eeprom_bus_pins_protect;
   timeunit 1ns;
   timeprecision 100ps;
   localparam [127:0] SN = 128'h1032547698BADCFE0123456789ABCDEF; // Arbitrary value
   localparam integer TWR = 200; // Short program time, still outlasts the first poll
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic wp = 1'b0; // Driven low stands in for the internal pull-down
   logic ce = 1'b1;
   logic ak;
   wire scl;
   wire sda;
   wire sda_oe;
   wire busy;
   int num_errors = 0;
   int checked = 0;

   sep_top #(.P_TWR_CYC(TWR), .P_SERIAL(SN)) u_dut (.i_mclk(clk), .i_sys_rst(rst), .i_ce(ce),
      .i_scl(scl), .i_sda(sda), .i_wp(wp), .o_sda_out(), .o_sda_oe(sda_oe), .o_busy(busy));
   sep_ctl_model u_ctl (.i_dev_oe(sda_oe), .o_scl(scl), .o_sda(sda));

   initial begin
      forever #4 clk = ~clk;
   end

   // ******************
   // Shared tasks
   // ******************
   task give_verdict;
      $display("comparisons %0d, mismatches %0d", checked, num_errors);
      if (num_errors == 0 && checked > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask
   task chk(input logic [7:0] got, input logic [7:0] exp, input string what);
      checked++;
      if (got !== exp) begin
         num_errors++;
         $display("wrong value at %0t: %s got %h want %h", $time, what, got, exp);
      end
   endtask
   // Open a frame at an address, polling while a program cycle runs
   task open_at(input logic [3:0] code, input logic [10:0] a, output int tries);
      tries = 0;
      ak = 1'b0;
      while (!ak && tries < 40) begin
         u_ctl.bus_start();
         u_ctl.wbyte({code, a[10:8], 1'b0}, ak);
         if (!ak) u_ctl.bus_stop();
         tries++;
      end
      chk({7'h00, ak}, 8'h01, "control ack");
      if (!ak) give_verdict();
      u_ctl.wbyte(a[7:0], ak);
      chk({7'h00, ak}, 8'h01, "address ack");
   endtask
   // Random read followed by sequential bytes
   task read_at(input logic [3:0] code, input logic [10:0] a, input int n,
                output logic [7:0] q [16], output int tries);
      open_at(code, a, tries);
      u_ctl.bus_start();
      u_ctl.wbyte({code, a[10:8], 1'b1}, ak);
      chk({7'h00, ak}, 8'h01, "read control ack");
      for (int i = 0; i < n; i++) u_ctl.rbyte(i == n - 1, q[i]);
      u_ctl.bus_stop();
   endtask
   // Write n bytes, each expected to be acked or refused
   task write_at(input logic [10:0] a, input int n, input logic [7:0] d [16], input logic exp_ack);
      int t;
      open_at(4'hA, a, t);
      for (int i = 0; i < n; i++) begin
         u_ctl.wbyte(d[i], ak);
         chk({7'h00, ak}, {7'h00, exp_ack}, "data ack");
      end
      u_ctl.bus_stop();
   endtask

   // ******************
   // Scenarios
   // ******************
   // Partial page from low nibble E wraps inside the top block
   task t_page;
      logic [7:0] d [16];
      logic [7:0] q [16];
      int t;
      d = '{default: 8'h00};
      d[0] = 8'h5A;
      d[1] = 8'hC3;
      d[2] = 8'h96;
      write_at(11'h72E, 3, d, 1'b1);
      repeat (2) @(negedge clk);
      chk({7'h00, busy}, 8'h01, "busy after stop");
      read_at(4'hA, 11'h72E, 2, q, t);
      chk(t > 1, 8'h01, "busy poll refused");
      chk(q[0], 8'h5A, "byte 72E");
      chk(q[1], 8'hC3, "byte 72F");
      read_at(4'hA, 11'h720, 1, q, t);
      chk(q[0], 8'h96, "wrapped byte");
      $display("test page done");
   endtask
   // Serial number reads back whole and refuses writes
   task t_serial;
      logic [7:0] q [16];
      int t;
      read_at(4'hB, 11'h000, 16, q, t);
      for (int i = 0; i < 16; i++) chk(q[i], SN[127 - 8 * i -: 8], "serial byte");
      open_at(4'hB, 11'h003, t);
      u_ctl.wbyte(8'h00, ak);
      chk({7'h00, ak}, 8'h00, "serial write ack");
      u_ctl.bus_stop();
      read_at(4'hB, 11'h003, 1, q, t);
      chk(q[0], SN[103:96], "serial kept");
      read_at(4'hA, 11'h72E, 1, q, t);
      chk(q[0], 8'h5A, "array apart");
      $display("test serial done");
   endtask
   // Protection held for the frame, then lifted
   task t_protect;
      logic [7:0] d [16];
      logic [7:0] q [16];
      int t;
      d = '{default: 8'h11};
      @(negedge clk) wp = 1'b1;
      write_at(11'h72E, 1, d, 1'b0);
      open_at(4'hA, 11'h72F, t);
      @(negedge clk) wp = 1'b0;
      u_ctl.wbyte(8'h22, ak);
      chk({7'h00, ak}, 8'h00, "latched protect");
      u_ctl.bus_stop();
      read_at(4'hA, 11'h72E, 2, q, t);
      chk(q[0], 8'h5A, "protected byte");
      chk(q[1], 8'hC3, "latched byte");
      d[0] = 8'h77;
      write_at(11'h72F, 1, d, 1'b1);
      read_at(4'hA, 11'h72F, 1, q, t);
      chk(q[0], 8'h77, "unprotected byte");
      $display("test protect done");
   endtask

   initial begin
      #400000;
      num_errors++;
      $display("wrong value at %0t: run timed out", $time);
      give_verdict();
   end

   initial begin
      repeat (5) @(posedge clk);
      @(negedge clk) rst = 1'b0;
      repeat (4) @(negedge clk);
      t_page();
      t_serial();
      t_protect();
      give_verdict();
   end
endmodule
